// file: core/acis_top.sv
// acis_top: channel input select, result rate scan and serial port of the converter
// assumes serial pins are asynchronous to mclk; adc_sample comes from mclk logic
//
// Summary of operation
// - results are 24-bit two's complement values
// - rates span 1.6775 to 214.65 samples per second
// - four wire serial port: select, clock, in, out
// - serial output doubles as active low ready
// - each channel holds its own reference select
// - reset selects first reference pair everywhere
// - positive and negative selects choose any input
// - differential use gives at most four channels
// - single-ended use gives at most seven channels
// - select fields hold the binary input index
`timescale 1ns/100ps
module acis_top #(
    parameter int FAST_PERIOD_CYCLES = int'(acis_pkg::FAST_CYCLES), // mclk cycles per 214.65 SPS result
    parameter int SLOW_PERIOD_CYCLES = int'(acis_pkg::SLOW_CYCLES) // mclk cycles per 13.42 SPS result
) (
    input wire logic mclk, // block clock, 25 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic chip_select_n, // serial select pin, active low
    input wire logic sclk, // serial clock pin
    input wire logic sdi, // serial data in pin
    output logic serial_out_data_ready_n, // serial data out, ready low between transfers
    output logic serial_out_oe, // drive enable of the serial out pin
    input wire logic single_ended_mode, // strap: 1 = single-ended, 0 = differential
    input wire logic [acis_pkg::RESULT_W-1:0] adc_sample, // filtered sample from the modulator
    output logic [acis_pkg::SEL_W-1:0] positive_input_select, // positive mux leg
    output logic [acis_pkg::SEL_W-1:0] negative_input_select, // negative mux leg
    output logic ref_select, // 0 first_reference_pair, 1 second_reference_pair
    output logic [acis_pkg::CH_W-1:0] active_channel, // channel being converted
    output logic conv_strobe // one cycle when a result is taken
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic cs_s1_reg, cs_s2_reg; // select
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg; // clock, third stage for edges
    logic sdi_s1_reg, sdi_s2_reg; // data in
    logic se_s1_reg, se_s2_reg; // mode strap

    // two flops per pin before any logic
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {cs_s1_reg, cs_s2_reg} <= 2'h3;
            {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h7;
            {sdi_s1_reg, sdi_s2_reg} <= 2'h0;
            {se_s1_reg, se_s2_reg} <= 2'h0;
        end else begin
            {cs_s1_reg, cs_s2_reg} <= {chip_select_n, cs_s1_reg};
            {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {sclk, sclk_s1_reg, sclk_s2_reg};
            {sdi_s1_reg, sdi_s2_reg} <= {sdi, sdi_s1_reg};
            {se_s1_reg, se_s2_reg} <= {single_ended_mode, se_s1_reg};
        end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire cs_act = ~cs_s2_reg; // transfer framed
    wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg; // host holds data, device samples
    wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg; // device shifts out
    wire [acis_pkg::CH_W:0] ch_limit = acis_pkg::acis_ch_limit(se_s2_reg);

    acis_pkg::acis_state_e state_reg, state_next; // serial engine
    logic [acis_pkg::CNT_W-1:0] cnt_reg; // bit within byte
    logic [acis_pkg::BYTE_W-1:0] sh_in_reg; // incoming bits
    logic [acis_pkg::BYTE_W-1:0] cmd_reg; // latched command
    logic [acis_pkg::RESULT_W-1:0] sh_out_reg; // outgoing bits, msb first
    logic load_reg; // read data due next cycle
    logic ready_reg; // fresh result waiting
    logic [acis_pkg::RESULT_W-1:0] result_reg; // latest result
    logic [acis_pkg::CH_W-1:0] seq_ch_reg; // scanned channel
    logic [acis_pkg::TMR_W-1:0] tmr_reg; // conversion timer

    wire [acis_pkg::BYTE_W-1:0] byte_in = {sh_in_reg[acis_pkg::BYTE_W-2:0], sdi_s2_reg}; // byte with last bit
    wire byte_done = sclk_rise && cnt_reg == acis_pkg::LAST_BIT; // eighth rising edge
    wire cmd_rd = cmd_reg[acis_pkg::CMD_RD_BIT]; // read command
    wire [acis_pkg::CH_W-1:0] cmd_ch = cmd_reg[acis_pkg::CMD_CH_LSB +: acis_pkg::CH_W]; // addressed channel
    wire [3:0] cmd_regsel = cmd_reg[3:0]; // addressed register
    wire ch_ok = {1'b0, cmd_ch} < ch_limit; // channel exists in this mode
    wire cmd_take = state_reg == acis_pkg::ST_CMD && byte_done; // command byte complete
    wire rd_result = cmd_take && byte_in[acis_pkg::CMD_RD_BIT] && byte_in[3:0] == acis_pkg::REG_RESULT;

    // ----------------------------------------------------------------
    // config store
    // ----------------------------------------------------------------
    acis_cfg_if cfg_bus ();

    acis_cfg_mem u_mem (
        .mclk(mclk),
        .rst_b(rst_b),
        .cfg(cfg_bus.mem)
    );

    wire [acis_pkg::CFG_W-1:0] row_a = cfg_bus.rdata_a; // addressed channel word
    wire [acis_pkg::CFG_W-1:0] row_b = cfg_bus.rdata_b; // scanned channel word
    wire wr_commit = state_reg == acis_pkg::ST_DATA && byte_done && !cmd_rd && ch_ok;
    // merge the data byte into the addressed row; no conflict check is made
    wire [acis_pkg::CFG_W-1:0] row_input = {row_a[acis_pkg::RATE_LSB +: acis_pkg::RATE_W],
                                            byte_in[acis_pkg::REF_BIT:0]};
    wire [acis_pkg::CFG_W-1:0] row_rate = {byte_in[acis_pkg::RATE_W-1:0], row_a[acis_pkg::REF_BIT:0]};

    assign cfg_bus.we = wr_commit && (cmd_regsel == acis_pkg::REG_INPUT || cmd_regsel == acis_pkg::REG_RATE);
    assign cfg_bus.waddr = cmd_ch;
    assign cfg_bus.wdata = cmd_regsel == acis_pkg::REG_RATE ? row_rate : row_input;
    // the new command's channel is read as the command completes, so the word stands when the shifter loads
    assign cfg_bus.raddr_a = cmd_take ? byte_in[acis_pkg::CMD_CH_LSB +: acis_pkg::CH_W] : cmd_ch;
    assign cfg_bus.raddr_b = seq_ch_reg;

    // read word, left aligned so its msb goes first
    wire [acis_pkg::RESULT_W-1:0] rd_word =
        cmd_regsel == acis_pkg::REG_RESULT ? result_reg :
        !ch_ok ? '0 :
        cmd_regsel == acis_pkg::REG_INPUT ? {1'b0, row_a[acis_pkg::REF_BIT:0], 16'h0000} :
        cmd_regsel == acis_pkg::REG_RATE ? {5'h00, row_a[acis_pkg::RATE_LSB +: acis_pkg::RATE_W], 16'h0000} :
        '0;

    // ----------------------------------------------------------------
    // serial engine
    // ----------------------------------------------------------------
    // next state of the serial frame
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            acis_pkg::ST_IDLE: begin
                if (cs_act) state_next = acis_pkg::ST_CMD;
            end
            acis_pkg::ST_CMD: begin
                if (byte_done) state_next = acis_pkg::ST_DATA;
            end
            acis_pkg::ST_DATA: begin
                if (byte_done && !cmd_rd) state_next = acis_pkg::ST_DONE; // one write byte only
            end
            acis_pkg::ST_DONE: begin
                state_next = acis_pkg::ST_DONE; // extra bits ignored
            end
            default: begin
                state_next = acis_pkg::ST_IDLE;
            end
        endcase
        if (!cs_act) state_next = acis_pkg::ST_IDLE; // select high ends any frame
    end

    // state, bit counter and input shifter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= acis_pkg::ST_IDLE;
            cnt_reg <= '0;
            sh_in_reg <= '0;
            cmd_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == acis_pkg::ST_IDLE) cnt_reg <= '0;
            else if (sclk_rise) cnt_reg <= cnt_reg + 3'h1;
            if (sclk_rise) sh_in_reg <= byte_in;
            if (cmd_take) cmd_reg <= byte_in;
        end
    end

    // output shifter and pin; ready shows outside the read data phase
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            load_reg <= 1'b0;
            sh_out_reg <= '0;
            serial_out_data_ready_n <= 1'b1;
            serial_out_oe <= 1'b0;
        end else begin
            load_reg <= cmd_take && byte_in[acis_pkg::CMD_RD_BIT];
            serial_out_oe <= cs_act;
            if (load_reg) sh_out_reg <= rd_word;
            else if (sclk_fall && state_reg == acis_pkg::ST_DATA) sh_out_reg <= sh_out_reg << 1;
            if (state_reg == acis_pkg::ST_DATA && cmd_rd) begin
                if (sclk_fall) serial_out_data_ready_n <= sh_out_reg[acis_pkg::RESULT_W-1];
            end else begin
                serial_out_data_ready_n <= ~ready_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // conversion scan
    // ----------------------------------------------------------------
    wire [acis_pkg::TMR_W-1:0] period = acis_pkg::acis_period(row_b[acis_pkg::RATE_LSB +: acis_pkg::RATE_W],
        acis_pkg::TMR_W'(FAST_PERIOD_CYCLES), acis_pkg::TMR_W'(SLOW_PERIOD_CYCLES));
    wire conv_done = tmr_reg >= period - 24'h000001; // period elapsed
    wire [acis_pkg::CH_W:0] ch_inc = {1'b0, seq_ch_reg} + 4'h1; // next channel index
    wire ch_wrap = ch_inc >= ch_limit;

    // timer, channel walk and result capture; a new result beats a clearing read
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_reg <= '0;
            seq_ch_reg <= '0;
            result_reg <= '0;
            ready_reg <= 1'b0;
            conv_strobe <= 1'b0;
        end else begin
            conv_strobe <= conv_done;
            if (conv_done) begin
                tmr_reg <= '0;
                seq_ch_reg <= ch_wrap ? '0 : ch_inc[acis_pkg::CH_W-1:0];
                result_reg <= adc_sample;
                ready_reg <= 1'b1;
            end else begin
                tmr_reg <= tmr_reg + 24'h000001;
                if (rd_result) ready_reg <= 1'b0;
            end
        end
    end

    // analog mux drive; the host keeps inputs six and seven free on the second pair
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            positive_input_select <= '0;
            negative_input_select <= '0;
            ref_select <= acis_pkg::REF_FIRST;
            active_channel <= '0;
        end else begin
            positive_input_select <= row_b[acis_pkg::POS_LSB +: acis_pkg::SEL_W];
            negative_input_select <= row_b[acis_pkg::NEG_LSB +: acis_pkg::SEL_W];
            ref_select <= row_b[acis_pkg::REF_BIT];
            active_channel <= seq_ch_reg;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_result_capture: assert property (@(posedge mclk) disable iff (!rst_b)
        conv_strobe |-> result_reg == $past(adc_sample) && ready_reg)
        else $error("result not taken from sample");

    a_period_bound: assert property (@(posedge mclk) disable iff (!rst_b)
        tmr_reg < acis_pkg::TMR_W'(SLOW_PERIOD_CYCLES) << 3)
        else $error("conversion timer beyond slowest rate");

    a_pin_released: assert property (@(posedge mclk) disable iff (!rst_b)
        cs_s2_reg ##1 cs_s2_reg |-> !serial_out_oe)
        else $error("serial out driven while deselected");

    a_ready_shown: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == acis_pkg::ST_CMD ##1 cs_act |-> serial_out_data_ready_n == !$past(ready_reg))
        else $error("ready not shown on serial out");

    a_ready_cleared: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_result && !conv_done |=> !ready_reg ##1 (!ready_reg || conv_strobe))
        else $error("result read did not clear ready");

    a_scan_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
        conv_done && ch_wrap |=> seq_ch_reg == '0)
        else $error("scan passed the channel limit");

    a_write_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg_bus.we |-> {1'b0, cfg_bus.waddr} < ch_limit)
        else $error("write to a channel beyond the limit");

    a_mux_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        $stable(seq_ch_reg) ##1 $stable(seq_ch_reg) && !$past(cfg_bus.we) |=>
            positive_input_select == $past(row_b[acis_pkg::POS_LSB +: acis_pkg::SEL_W]) &&
            negative_input_select == $past(row_b[acis_pkg::NEG_LSB +: acis_pkg::SEL_W]))
        else $error("mux selects do not follow the channel word");
endmodule : acis_top

// file: core/acis_pkg.sv
// acis_pkg: shared constants, field layouts and helpers of the channel input select block
// assumes a 25 MHz mclk and a serial clock sampled by mclk
package acis_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int RESULT_W = 24; // conversion result width
    localparam int SEL_W = 3; // analog input index width
    localparam int RATE_W = 3; // result rate code width
    localparam int CH_W = 3; // channel index width
    localparam int CFG_W = 10; // stored word per channel
    localparam int MEM_DEPTH = 8; // rows in the config store
    localparam int TMR_W = 24; // conversion period counter width
    localparam int BYTE_W = 8; // serial byte
    localparam int CNT_W = 3; // bit counter within a byte

    // ----------------------------------------------------------------
    // stored word layout: {rate, ref, pos, neg}
    // ----------------------------------------------------------------
    localparam int NEG_LSB = 0; // negative input select
    localparam int POS_LSB = 3; // positive input select
    localparam int REF_BIT = 6; // reference select
    localparam int RATE_LSB = 7; // result rate code
    localparam logic [CFG_W-1:0] CFG_RESET = 10'h380; // fastest rate, first reference pair, inputs 0/0
    localparam logic REF_FIRST = 1'h0; // first reference pair
    localparam logic REF_SECOND = 1'h1; // second reference pair

    // ----------------------------------------------------------------
    // serial command byte: {read, channel, register}
    // ----------------------------------------------------------------
    localparam int CMD_RD_BIT = 7; // 1 = read, 0 = write
    localparam int CMD_CH_LSB = 4; // channel field
    localparam logic [3:0] REG_INPUT = 4'h0; // channel_input_control
    localparam logic [3:0] REG_RATE = 4'h1; // per channel result_rate code
    localparam logic [3:0] REG_RESULT = 4'h2; // latest conversion result
    localparam logic [CNT_W-1:0] LAST_BIT = 3'h7; // last bit of a byte

    // ----------------------------------------------------------------
    // channel limits
    // ----------------------------------------------------------------
    localparam logic [CH_W:0] DIFF_CH_MAX = 4'h4; // differential channels
    localparam logic [CH_W:0] SE_CH_MAX = 4'h7; // single-ended channels

    // ----------------------------------------------------------------
    // timing: rates in micro samples per second
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 25000000; // mclk rate
    localparam longint USPS_PER_SPS = 1000000; // unit scale
    localparam longint RATE_FAST_USPS = 214650000; // 214.65 SPS base
    localparam longint RATE_SLOW_USPS = 13420000; // 13.42 SPS base
    localparam longint FAST_CYCLES = CLK_HZ * USPS_PER_SPS / RATE_FAST_USPS; // cycles per fast result
    localparam longint SLOW_CYCLES = CLK_HZ * USPS_PER_SPS / RATE_SLOW_USPS; // cycles per slow result

    // serial engine states, gray along idle-cmd-data-done
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CMD = 2'h1,
        ST_DATA = 2'h3,
        ST_DONE = 2'h2
    } acis_state_e;

    // cycles per conversion for a rate code: codes 0-3 slow x8..x1, 4-7 fast x8..x1
    function automatic logic [TMR_W-1:0] acis_period(input logic [RATE_W-1:0] code,
                                                     input logic [TMR_W-1:0] fast,
                                                     input logic [TMR_W-1:0] slow);
        logic [TMR_W-1:0] base;
        base = code[2] ? fast : slow;
        return base << (2'h3 - code[1:0]);
    endfunction : acis_period

    // number of usable channels for the input mode
    function automatic logic [CH_W:0] acis_ch_limit(input logic single_ended);
        return single_ended ? SE_CH_MAX : DIFF_CH_MAX;
    endfunction : acis_ch_limit
endpackage : acis_pkg

// file: core/acis_cfg_if.sv
// acis_cfg_if: carries the config store ports between the top and the store
// assumes both ends run on mclk
`timescale 1ns/100ps
interface acis_cfg_if;
    logic we; // write strobe
    logic [acis_pkg::CH_W-1:0] waddr; // write row
    logic [acis_pkg::CFG_W-1:0] wdata; // write word
    logic [acis_pkg::CH_W-1:0] raddr_a; // serial side read row
    logic [acis_pkg::CFG_W-1:0] rdata_a; // serial side read word
    logic [acis_pkg::CH_W-1:0] raddr_b; // scan side read row
    logic [acis_pkg::CFG_W-1:0] rdata_b; // scan side read word
    modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
    modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface : acis_cfg_if

// file: core/acis_cfg_mem.sv
// acis_cfg_mem: per channel input control store, one write port, two registered read ports
// assumes mclk domain and asynchronous active low reset
`timescale 1ns/100ps
module acis_cfg_mem (
    input wire logic mclk, // block clock
    input wire logic rst_b, // async reset, active low
    acis_cfg_if.mem cfg // store ports
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [acis_pkg::CFG_W-1:0] row_reg [acis_pkg::MEM_DEPTH]; // one word per channel

    // rows reset to the first reference pair and fastest rate
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < acis_pkg::MEM_DEPTH; i++) begin
                row_reg[i] <= acis_pkg::CFG_RESET;
            end
        end else if (cfg.we) begin
            row_reg[cfg.waddr] <= cfg.wdata;
        end
    end

    // registered read ports
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg.rdata_a <= acis_pkg::CFG_RESET;
            cfg.rdata_b <= acis_pkg::CFG_RESET;
        end else begin
            cfg.rdata_a <= row_reg[cfg.raddr_a];
            cfg.rdata_b <= row_reg[cfg.raddr_b];
        end
    end

    // a written reference select is what the row then holds
    a_ref_write_kept: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg.we |=> row_reg[$past(cfg.waddr)][acis_pkg::REF_BIT] == $past(cfg.wdata[acis_pkg::REF_BIT]))
        else $error("reference select not stored");
endmodule : acis_cfg_mem

// file: sim/acis_host.sv
// acis_host: serial host model, drives select, clock and data in, gathers data out
// assumes mclk only aligns frame starts; sclk idles low, 320 ns period
`timescale 1ns/100ps
module acis_host (
    input wire logic mclk, // alignment clock
    output logic chip_select_n, // select, active low
    output logic sclk, // serial clock, still outside frames
    output logic sdi, // host to device data
    input wire logic serial_out_data_ready_n, // device out pin
    input wire logic serial_out_oe // device drive enable
);
    logic miso; // pin level, pulled high when released
    assign miso = serial_out_oe ? serial_out_data_ready_n : 1'b1;
    initial begin
        chip_select_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // ----------------------------------------------------------------
    // one frame: n bits msb first from tx[31], rx filled the same way
    // ----------------------------------------------------------------
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx, output logic rdy_n);
        @(posedge mclk);
        #1 chip_select_n = 1'b0;
        #160 rdy_n = miso; // ready level before the first clock
        rx = 32'h0;
        for (int i = 0; i < n; i++) begin
            sdi = tx[31-i];
            #160 sclk = 1'b1;
            #160 rx[31-i] = miso; // late in the bit, data long settled
            sclk = 1'b0;
        end
        #160 chip_select_n = 1'b1;
        sdi = ~sdi; // released line does not keep its value
        #200;
    endtask : frame
endmodule : acis_host

// file: sim/acis_top_bench.sv
// acis_top_bench: self-checking bench of the channel input select block
// assumes acis_host on the serial pins and shortened conversion periods
`timescale 1ns/100ps
module acis_top_bench;
    localparam int FAST = 20; // shortened fast period
    localparam int SLOW = 40; // shortened slow period
    logic mclk = 1'b0; // 25 MHz clock
    logic rst_b = 1'b0; // reset, active low
    logic single_ended_mode = 1'b0; // strap
    logic [acis_pkg::RESULT_W-1:0] adc_sample = 24'h0; // modulator sample
    logic chip_select_n, sclk, sdi, sdo, oe, ref_select, conv_strobe; // pins and flags
    logic [acis_pkg::SEL_W-1:0] pos, neg; // mux legs
    logic [acis_pkg::CH_W-1:0] ch; // scanned channel
    int cfg[8]; // model of the input control rows
    int errors = 0;
    int checks = 0;
    logic [31:0] seed = 32'h42; // xorshift state, starts at 66
    always #20 mclk = ~mclk;
    acis_top #(.FAST_PERIOD_CYCLES(FAST), .SLOW_PERIOD_CYCLES(SLOW)) u_dut (.mclk(mclk), .rst_b(rst_b),
        .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi), .serial_out_data_ready_n(sdo),
        .serial_out_oe(oe), .single_ended_mode(single_ended_mode), .adc_sample(adc_sample),
        .positive_input_select(pos), .negative_input_select(neg), .ref_select(ref_select),
        .active_channel(ch), .conv_strobe(conv_strobe));
    acis_host u_host (.mclk(mclk), .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi),
        .serial_out_data_ready_n(sdo), .serial_out_oe(oe));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int lim(); // usable channels for the strap
        return single_ended_mode ? 7 : 4;
    endfunction : lim
    task automatic end_sim();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk_byte(input logic [7:0] got, input int exp);
        checks++;
        if (got !== 8'(exp)) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, 8'(exp));
        end
    endtask : chk_byte
    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    // waits for a result pulse, returns cycles spent
    task automatic wait_strobe(output int k);
        for (k = 1; k <= 1000; k++) begin
            @(posedge mclk);
            #1;
            if (conv_strobe === 1'b1) return;
        end
        errors++;
        end_sim();
    endtask : wait_strobe
    task automatic wr(input int c, input logic [3:0] rg, input logic [7:0] d);
        logic [31:0] rx;
        logic r;
        u_host.frame({1'b0, 3'(c), rg, d, 16'h0}, 16, rx, r);
        if (rg == acis_pkg::REG_INPUT && c < lim()) cfg[c] = int'(d[6:0]); // refused beyond the limit
    endtask : wr
    task automatic rd_all();
        logic [31:0] rx;
        logic r;
        for (int c = 0; c < 8; c++) begin
            u_host.frame({1'b1, 3'(c), acis_pkg::REG_INPUT, 24'h0}, 16, rx, r);
            chk_byte(rx[23:16], c < lim() ? cfg[c] : 0);
        end
    endtask : rd_all
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] v;
        logic [31:0] rx;
        logic r;
        int k;
        int nxt;
        repeat (6) @(posedge mclk);
        chk_byte({oe, ref_select, pos, neg}, 0);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge mclk);
        for (int m = 0; m < 2; m++) begin
            @(posedge mclk) #1 single_ended_mode = m[0];
            rd_all(); // reset rows first, then what survives the strap change
            for (int c = 0; c < 8; c++) begin
                v = rnd();
                if (m == 1 && v[6]) v[5:0] = {1'b0, v[4:3], 1'b0, v[1:0]};
                wr(c, acis_pkg::REG_INPUT, v); // differential pass keeps conflicts
            end
            rd_all();
        end
        wait_strobe(k);
        nxt = int'(ch);
        for (int i = 0; i < 9; i++) begin
            repeat (3) @(posedge mclk);
            #1 chk_byte({1'b0, ref_select, pos, neg}, cfg[ch]);
            wait_strobe(k);
            chk_byte(8'(k + 3), FAST);
            nxt = (nxt + 1) % lim();
            chk_byte({5'h0, ch}, nxt);
        end
        for (int c = 0; c < 7; c++) wr(c, acis_pkg::REG_RATE, 8'h0);
        repeat (2) wait_strobe(k);
        wait_strobe(k);
        chk_byte(8'(k >> 3), SLOW);
        for (int i = 0; i < 3; i++) begin
            adc_sample = 24'(rnd());
            repeat (2) wait_strobe(k);
            u_host.frame({1'b1, 3'h0, acis_pkg::REG_RESULT, 24'h0}, 32, rx, r);
            chk_word(rx[23:0], adc_sample);
            chk_byte({7'h0, r}, 0);
        end
        end_sim();
    end
endmodule : acis_top_bench
